// ==== src/dtcnt_core.sv ====
// Contract
// - normal mode: 16-bit count, decrement, end at zero
// - normal count 0001 one, FFFF 65535, 0000 65536
// - repeat: low byte counts, reloads from high
// - repeat 01 one, FF 255, 00 256
// - block: low byte counts block, reloads from high
// - block size 01 one, FF 255, 00 256
// - block: count B decrements per block, ends zero
// - five 8-bit enables route sources to transfers
// - enable clears on per-transfer select or count end
// - enable bits map to fixed vector numbers
// - writing one to sw enable starts transfer
// - sw enable clears as specified, else stays
// - vector address is 0400 plus twice number
// - vector number writable only while sw enable zero
// - cpu request every transfer or at count end
// - mode 00 normal, 01 repeat, 10 block, 11 prohibited
// - chain skips end decision and flag clearing
module dtcnt_core #(
  parameter int NSRC = 40
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // interrupt controller side
  input wire logic [NSRC-1:0] src_req_in,
  output logic src_clr_out,
  output logic [5:0] src_clr_idx_out,
  // transfer engine side
  output logic xfer_strobe_out,
  output logic [15:0] vec_addr_out,
  output logic busy_out,
  // cpu interrupt
  output logic irq_out
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_XFER = 3'b010,
    ST_DONE = 3'b100
  } dtcnt_state_e;

  typedef struct packed {
    dtcnt_state_e st;
    logic [1:0] mode;
    logic per_transfer_irq_select;
    logic chain_enable;
    logic [15:0] cnt_a;
    logic [15:0] cnt_b;
    logic [NSRC-1:0] en;
    logic sw_activation_enable;
    logic sw_pend;
    logic sw_end_sent;
    logic [6:0] swvec;
    logic [2:0] sts;
    logic [2:0] msk;
    logic cur_sw;
    logic [5:0] cur_idx;
    logic cnt_end;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] hrdata;
    logic hready;
    logic irq;
    logic xfer_strobe;
    logic src_clr;
    logic [15:0] vec_addr;
    logic busy;
  } dtcnt_regs_s;

  dtcnt_regs_s q_reg;
  dtcnt_regs_s q_next;
  logic [NSRC-1:0] pend;
  logic found;
  logic [5:0] pick;
  logic [2:0] sts_set;
  logic [2:0] sts_clr;
  logic [7:0] low_dec;

  // ------------------------------------------------------------------
  // register read mux
  // ------------------------------------------------------------------
  function automatic logic [31:0] rd_val(input dtcnt_regs_s s, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      dtcnt_pkg::OFF_MODE: begin
        v[dtcnt_pkg::MODE_LSB +: 2] = s.mode;
        v[dtcnt_pkg::PER_TRANSFER_IRQ_SELECT_BIT] = s.per_transfer_irq_select;
        v[dtcnt_pkg::CHAIN_BIT] = s.chain_enable;
      end
      dtcnt_pkg::OFF_COUNT_A: v[15:0] = s.cnt_a;
      dtcnt_pkg::OFF_COUNT_B: v[15:0] = s.cnt_b;
      dtcnt_pkg::OFF_SW_VECTOR: v[7:0] = {s.sw_activation_enable, s.swvec};
      dtcnt_pkg::OFF_IRQ_STATUS: v[2:0] = s.sts;
      dtcnt_pkg::OFF_IRQ_MASK: v[2:0] = s.msk;
      dtcnt_pkg::OFF_STATE: v = {s.vec_addr, 8'h00, s.cur_idx, s.cur_sw, s.st != ST_IDLE};
      default: begin
        for (int k = 0; k < dtcnt_pkg::NUM_EN_REGS; k++) begin
          if (a == dtcnt_pkg::OFF_ENABLE_A + 8'(k) * dtcnt_pkg::OFF_ENABLE_STEP) begin
            v[7:0] = s.en[k*8 +: 8];
          end
        end
      end
    endcase
    return v;
  endfunction : rd_val

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    q_next = q_reg;
    q_next.xfer_strobe = 1'b0;
    q_next.src_clr = 1'b0;
    sts_set = 3'b000;
    sts_clr = 3'b000;
    found = 1'b0;
    pick = 6'd0;
    low_dec = q_reg.cnt_a[7:0] - 8'h01;
    pend = q_reg.en & src_req_in;
    // flag clear lands one edge late; a stale flag must not restart us
    if (q_reg.src_clr) begin
      pend[q_reg.cur_idx] = 1'b0;
    end
    // lowest index wins, matching fixed priority of the sources
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        found = 1'b1;
        pick = 6'(i);
      end
    end

    case (q_reg.st)
      ST_IDLE: begin
        if (found || q_reg.sw_pend) begin
          q_next.cur_sw = !found;
          if (found) begin
            q_next.cur_idx = pick;
            q_next.vec_addr = dtcnt_pkg::VEC_BASE + {8'h00, dtcnt_pkg::SRC_VECTOR[pick], 1'b0};
          end else begin
            q_next.sw_pend = 1'b0;
            q_next.vec_addr = dtcnt_pkg::VEC_BASE + {8'h00, q_reg.swvec, 1'b0};
          end
          if (q_reg.mode == dtcnt_pkg::MODE_PROHIB) begin
            // refuse to run; drop the enable so a level source cannot lock us up
            sts_set[dtcnt_pkg::STS_BAD_MODE] = 1'b1;
            if (found) begin
              q_next.en[pick] = 1'b0;
            end
          end else begin
            q_next.st = ST_XFER;
          end
        end
      end
      ST_XFER: begin
        q_next.xfer_strobe = 1'b1;
        case (q_reg.mode)
          dtcnt_pkg::MODE_NORMAL: begin
            // zero wraps to FFFF, giving 65536 transfers
            q_next.cnt_a = q_reg.cnt_a - 16'h0001;
            q_next.cnt_end = (q_reg.cnt_a == 16'h0001);
            q_next.st = ST_DONE;
          end
          dtcnt_pkg::MODE_REPEAT: begin
            q_next.cnt_a[7:0] = (low_dec == 8'h00) ? q_reg.cnt_a[15:8] : low_dec;
            q_next.cnt_end = 1'b0;
            q_next.st = ST_DONE;
          end
          default: begin
            // one unit per cycle until the block size counter expires
            if (low_dec == 8'h00) begin
              q_next.cnt_a[7:0] = q_reg.cnt_a[15:8];
              q_next.cnt_b = q_reg.cnt_b - 16'h0001;
              q_next.cnt_end = (q_reg.cnt_b == 16'h0001);
              q_next.st = ST_DONE;
            end else begin
              q_next.cnt_a[7:0] = low_dec;
            end
          end
        endcase
      end
      ST_DONE: begin
        q_next.st = ST_IDLE;
        if (!q_reg.chain_enable) begin
          if (q_reg.per_transfer_irq_select || q_reg.cnt_end) begin
            sts_set[dtcnt_pkg::STS_XFER_IRQ] = 1'b1;
          end
          if (!q_reg.cur_sw) begin
            if (q_reg.per_transfer_irq_select || q_reg.cnt_end) begin
              q_next.en[q_reg.cur_idx] = 1'b0;
            end else begin
              q_next.src_clr = 1'b1;
            end
          end else if (!q_reg.per_transfer_irq_select && !q_reg.cnt_end) begin
            q_next.sw_activation_enable = 1'b0;
          end else begin
            sts_set[dtcnt_pkg::STS_SW_END] = 1'b1;
            q_next.sw_end_sent = 1'b1;
          end
        end
      end
      default: q_next.st = ST_IDLE;
    endcase

    // bus address phase: zero wait, read data registered for the data phase
    q_next.wr_pend = 1'b0;
    q_next.hready = 1'b1;
    if (hsel_in && hready_in && htrans_in[1]) begin
      q_next.wr_pend = hwrite_in;
      q_next.wr_addr = haddr_in[7:0];
      q_next.hrdata = hwrite_in ? 32'h0000_0000 : rd_val(q_reg, haddr_in[7:0]);
    end

    // bus data phase: software write lands after the engine update
    if (q_reg.wr_pend) begin
      case (q_reg.wr_addr)
        dtcnt_pkg::OFF_MODE: begin
          q_next.mode = hwdata_in[dtcnt_pkg::MODE_LSB +: 2];
          q_next.per_transfer_irq_select = hwdata_in[dtcnt_pkg::PER_TRANSFER_IRQ_SELECT_BIT];
          q_next.chain_enable = hwdata_in[dtcnt_pkg::CHAIN_BIT];
          if (!hwdata_in[dtcnt_pkg::PER_TRANSFER_IRQ_SELECT_BIT] && q_reg.sw_end_sent) begin
            q_next.sw_activation_enable = 1'b0;
            q_next.sw_end_sent = 1'b0;
          end
        end
        dtcnt_pkg::OFF_COUNT_A: q_next.cnt_a = hwdata_in[15:0];
        dtcnt_pkg::OFF_COUNT_B: q_next.cnt_b = hwdata_in[15:0];
        dtcnt_pkg::OFF_SW_VECTOR: begin
          if (!q_reg.sw_activation_enable) begin
            q_next.swvec = hwdata_in[6:0];
            // only a one takes effect on the enable
            if (hwdata_in[dtcnt_pkg::SW_ACTIVATION_ENABLE_BIT]) begin
              q_next.sw_activation_enable = 1'b1;
              q_next.sw_pend = 1'b1;
            end
          end
        end
        dtcnt_pkg::OFF_IRQ_STATUS: sts_clr = hwdata_in[2:0];
        dtcnt_pkg::OFF_IRQ_MASK: q_next.msk = hwdata_in[2:0];
        default: begin
          for (int k = 0; k < dtcnt_pkg::NUM_EN_REGS; k++) begin
            if (q_reg.wr_addr == dtcnt_pkg::OFF_ENABLE_A + 8'(k) * dtcnt_pkg::OFF_ENABLE_STEP) begin
              // reserved positions cannot hold a one
              q_next.en[k*8 +: 8] = hwdata_in[7:0] & dtcnt_pkg::SRC_VALID[k*8 +: 8];
            end
          end
        end
      endcase
    end

    // set wins over write-one-to-clear
    q_next.sts = (q_reg.sts & ~sts_clr) | sts_set;
    q_next.irq = |(q_next.sts & q_next.msk);
    q_next.busy = (q_next.st != ST_IDLE);
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      q_reg <= '0;
      q_reg.st <= ST_IDLE;
      q_reg.cnt_a <= dtcnt_pkg::RST_COUNT;
      q_reg.cnt_b <= dtcnt_pkg::RST_COUNT;
      q_reg.swvec <= dtcnt_pkg::RST_SW_VECTOR[6:0];
      q_reg.sts <= dtcnt_pkg::RST_STS;
      q_reg.hready <= 1'b1;
    end else begin
      q_reg <= q_next;
    end
  end

  assign hrdata_out = q_reg.hrdata;
  assign hreadyout_out = q_reg.hready;
  assign hresp_out = 1'b0;
  assign src_clr_out = q_reg.src_clr;
  assign src_clr_idx_out = q_reg.cur_idx;
  assign xfer_strobe_out = q_reg.xfer_strobe;
  assign vec_addr_out = q_reg.vec_addr;
  assign busy_out = q_reg.busy;
  assign irq_out = q_reg.irq;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  logic en_cur;
  assign en_cur = q_reg.en[q_reg.cur_idx];

  sequence s_sw_write;
    q_reg.wr_pend && q_reg.wr_addr == dtcnt_pkg::OFF_SW_VECTOR && !q_reg.sw_activation_enable
      && hwdata_in[dtcnt_pkg::SW_ACTIVATION_ENABLE_BIT] && q_reg.st == ST_IDLE && !found
      && q_reg.mode != dtcnt_pkg::MODE_PROHIB;
  endsequence
  sequence s_sw_run;
    ##[2:3] (q_reg.st == ST_XFER && q_reg.cur_sw);
  endsequence

  property p_norm_dec;
    q_reg.st == ST_XFER && q_reg.mode == dtcnt_pkg::MODE_NORMAL && !q_reg.wr_pend
      |=> q_reg.cnt_a == $past(q_reg.cnt_a) - 16'h0001 && q_reg.st == ST_DONE;
  endproperty
  a_norm_dec: assert property (p_norm_dec) else $error("normal count not decremented");

  property p_norm_end;
    q_reg.st == ST_XFER && q_reg.mode == dtcnt_pkg::MODE_NORMAL
      |=> q_reg.cnt_end == ($past(q_reg.cnt_a) == 16'h0001);
  endproperty
  a_norm_end: assert property (p_norm_end) else $error("normal end flag wrong");

  property p_rep_reload;
    q_reg.st == ST_XFER && q_reg.mode == dtcnt_pkg::MODE_REPEAT
      && q_reg.cnt_a[7:0] == 8'h01 && !q_reg.wr_pend
      |=> q_reg.cnt_a[7:0] == q_reg.cnt_a[15:8] && !q_reg.cnt_end;
  endproperty
  a_rep_reload: assert property (p_rep_reload) else $error("repeat reload missing");

  property p_blk_block;
    q_reg.st == ST_XFER && q_reg.mode == dtcnt_pkg::MODE_BLOCK
      && q_reg.cnt_a[7:0] == 8'h01 && !q_reg.wr_pend
      |=> q_reg.cnt_a[7:0] == q_reg.cnt_a[15:8]
        && q_reg.cnt_b == $past(q_reg.cnt_b) - 16'h0001 && q_reg.st == ST_DONE;
  endproperty
  a_blk_block: assert property (p_blk_block) else $error("block end handling wrong");

  property p_blk_cont;
    q_reg.st == ST_XFER && q_reg.mode == dtcnt_pkg::MODE_BLOCK && q_reg.cnt_a[7:0] != 8'h01
      |=> q_reg.st == ST_XFER && q_reg.xfer_strobe;
  endproperty
  a_blk_cont: assert property (p_blk_cont) else $error("block ended early");

  property p_en_clear;
    q_reg.st == ST_DONE && !q_reg.cur_sw && !q_reg.chain_enable
      && (q_reg.per_transfer_irq_select || q_reg.cnt_end) && !q_reg.wr_pend
      |=> !en_cur && q_reg.irq == |(q_reg.sts & q_reg.msk);
  endproperty
  a_en_clear: assert property (p_en_clear) else $error("enable bit not cleared");

  property p_sw_start;
    s_sw_write |-> s_sw_run;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software start missing");

  property p_vec_addr;
    q_reg.st == ST_XFER && q_reg.cur_sw
      |-> q_reg.vec_addr == dtcnt_pkg::VEC_BASE + {8'h00, q_reg.swvec, 1'b0};
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong");

  property p_vec_lock;
    q_reg.sw_activation_enable |=> q_reg.swvec == $past(q_reg.swvec);
  endproperty
  a_vec_lock: assert property (p_vec_lock) else $error("vector changed while enabled");

  property p_cpu_req;
    q_reg.st == ST_DONE && !q_reg.chain_enable && q_reg.per_transfer_irq_select
      |=> q_reg.sts[dtcnt_pkg::STS_XFER_IRQ] ##1 irq_out == q_reg.msk[0] || q_reg.sts[2:1] != 2'b00;
  endproperty
  a_cpu_req: assert property (p_cpu_req) else $error("cpu request missing");

  property p_no_prohib;
    q_reg.st == ST_XFER |-> q_reg.mode != dtcnt_pkg::MODE_PROHIB;
  endproperty
  a_no_prohib: assert property (p_no_prohib) else $error("ran in prohibited mode");

  property p_chain;
    q_reg.st == ST_DONE && q_reg.chain_enable |=> !q_reg.src_clr && $stable(q_reg.en) || $past(q_reg.wr_pend);
  endproperty
  a_chain: assert property (p_chain) else $error("chain cleared flags");

endmodule : dtcnt_core

// ==== include/dtcnt_pkg.sv ====
package dtcnt_pkg;

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_COUNT_A = 8'h04;
  localparam logic [7:0] OFF_COUNT_B = 8'h08;
  localparam logic [7:0] OFF_ENABLE_A = 8'h0C;
  localparam logic [7:0] OFF_ENABLE_STEP = 8'h04;
  localparam logic [7:0] OFF_SW_VECTOR = 8'h20;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h24;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h28;
  localparam logic [7:0] OFF_STATE = 8'h2C;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int MODE_LSB = 2;
  localparam int PER_TRANSFER_IRQ_SELECT_BIT = 6;
  localparam int CHAIN_BIT = 7;
  localparam int SW_ACTIVATION_ENABLE_BIT = 7;
  localparam int STS_XFER_IRQ = 0;
  localparam int STS_SW_END = 1;
  localparam int STS_BAD_MODE = 2;
  localparam int NUM_EN_REGS = 5;
  localparam int NUM_SRC = 40;
  localparam int NUM_STS = 3;

  // ------------------------------------------------------------------
  // encodings and reset values
  // ------------------------------------------------------------------
  localparam logic [1:0] MODE_NORMAL = 2'b00;
  localparam logic [1:0] MODE_REPEAT = 2'b01;
  localparam logic [1:0] MODE_BLOCK = 2'b10;
  localparam logic [1:0] MODE_PROHIB = 2'b11;
  localparam logic [15:0] VEC_BASE = 16'h0400;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_SW_VECTOR = 8'h00;
  localparam logic [2:0] RST_STS = 3'h0;

  // source bits that exist; reserved positions hold zero
  localparam logic [39:0] SRC_VALID = 40'h0F_9817_60F8;

  // vector number per source, index = register * 8 + bit
  localparam logic [6:0] SRC_VECTOR [40] = '{
    7'd0, 7'd0, 7'd0, 7'd28, 7'd19, 7'd18, 7'd17, 7'd16,
    7'd0, 7'd0, 7'd0, 7'd0, 7'd0, 7'd94, 7'd76, 7'd0,
    7'd85, 7'd82, 7'd81, 7'd0, 7'd29, 7'd0, 7'd0, 7'd0,
    7'd0, 7'd0, 7'd0, 7'd98, 7'd78, 7'd0, 7'd0, 7'd86,
    7'd107, 7'd106, 7'd105, 7'd104, 7'd0, 7'd0, 7'd0, 7'd0
  };

endpackage : dtcnt_pkg

// ==== sim/dtcnt_intc_model.sv ====
module dtcnt_intc_model (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // bench side
  input wire logic raise_in,
  input wire logic [5:0] raise_idx_in,
  input wire logic flush_in,
  // controller side
  input wire logic src_clr_in,
  input wire logic [5:0] src_clr_idx_in,
  output logic [39:0] src_req_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // flags are sticky: only the controller's clear pulse, a flush or reset drops them
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in || flush_in) begin
      src_req_out <= '0;
    end else begin
      if (src_clr_in) begin
        src_req_out[src_clr_idx_in] <= 1'b0;
      end
      if (raise_in) begin
        src_req_out[raise_idx_in] <= 1'b1;
      end
    end
  end
endmodule : dtcnt_intc_model

// ==== sim/transfer_count_and_activation_tb_top.sv ====
module transfer_count_and_activation_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, nrst, hwrite, raise, flush, hready, src_clr, strobe, busy, irq, hresp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [5:0] raise_idx, src_clr_idx;
  logic [39:0] src_req;
  logic [15:0] vec, last_vec, rd;
  int mismatches = 0, total_checks = 0, strobes = 0, s0 = 0, k;
  // mode, start count, count after one unit
  logic [1:0] tm [7] = '{2'b00, 2'b00, 2'b00, 2'b01, 2'b01, 2'b01, 2'b01};
  logic [15:0] ts [7] = '{16'h0000, 16'h0001, 16'hFFFF, 16'h0202, 16'h0201, 16'h0000, 16'h0101};
  logic [15:0] te [7] = '{16'hFFFF, 16'h0000, 16'hFFFE, 16'h0201, 16'h0202, 16'h00FF, 16'h0101};
  // source index, enable register, bit, vector number
  logic [5:0] vi [3] = '{6'd7, 6'd20, 6'd32};
  int vr [3] = '{0, 2, 4};
  logic [7:0] vb [3] = '{8'h80, 8'h10, 8'h01};
  logic [15:0] vn [3] = '{16'd16, 16'd29, 16'd107};

  dtcnt_core i_dut (.core_clk_in(core_clk), .nrst_in(nrst), .hsel_in(1'b1), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .src_req_in(src_req), .src_clr_out(src_clr), .src_clr_idx_out(src_clr_idx),
    .xfer_strobe_out(strobe), .vec_addr_out(vec), .busy_out(busy), .irq_out(irq));

  dtcnt_intc_model i_intc (.core_clk_in(core_clk), .nrst_in(nrst), .raise_in(raise),
    .raise_idx_in(raise_idx), .flush_in(flush), .src_clr_in(src_clr),
    .src_clr_idx_in(src_clr_idx), .src_req_out(src_req));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (strobe === 1'b1) begin
      strobes <= strobes + 1;
      last_vec <= vec;
    end
  end

  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic results;
    $display("mismatches %0d checks %0d", mismatches, total_checks);
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge core_clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        mismatches++;
        results();
      end
      @(posedge core_clk);
    end
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= {16'h0000, d};
    wait_rdy();
    rd = hrdata[15:0];
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(nm, e, rd);
  endtask : rchk

  function automatic logic [7:0] eo(input int n);
    return dtcnt_pkg::OFF_ENABLE_A + 8'(n) * dtcnt_pkg::OFF_ENABLE_STEP;
  endfunction : eo

  // single-bit changes go through read-modify-write
  task automatic set_en(input int n, input logic [7:0] b);
    bus(1'b0, eo(n), 16'h0000);
    wr(eo(n), rd | {8'h00, b});
  endtask : set_en

  task automatic setup(input logic [1:0] md, input logic ds, input logic [15:0] ca,
                       input logic [15:0] cb);
    @(posedge core_clk);
    flush <= 1'b1;
    @(posedge core_clk);
    flush <= 1'b0;
    wr(dtcnt_pkg::OFF_MODE, {8'h00, 1'b0, ds, 2'b00, md, 2'b00});
    wr(dtcnt_pkg::OFF_COUNT_A, ca);
    wr(dtcnt_pkg::OFF_COUNT_B, cb);
    wr(dtcnt_pkg::OFF_IRQ_STATUS, 16'h0007);
  endtask : setup

  // prohibited mode may never raise busy, hence the short idle limit
  task automatic act(input logic hw, input logic [5:0] idx);
    int n;
    logic seen;
    seen = 1'b0;
    s0 = strobes;
    if (hw) begin
      @(posedge core_clk);
      raise <= 1'b1;
      raise_idx <= idx;
      @(posedge core_clk);
      raise <= 1'b0;
    end
    for (n = 0; n < 600; n++) begin
      @(posedge core_clk);
      if (busy === 1'b1) begin
        seen = 1'b1;
      end else if (seen || n > 10) begin
        break;
      end
    end
    if (n == 600) begin
      mismatches++;
      results();
    end
  endtask : act

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    haddr = '0;
    htrans = '0;
    hwrite = 1'b0;
    hwdata = '0;
    raise = 1'b0;
    raise_idx = '0;
    flush = 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    for (k = 0; k < 5; k++) begin
      rchk("enable reset", eo(k), 16'h0000);
      wr(eo(k), {8'h00, dtcnt_pkg::SRC_VALID[k*8 +: 8]});
      rchk("enable rw", eo(k), {8'h00, dtcnt_pkg::SRC_VALID[k*8 +: 8]});
      wr(eo(k), 16'h0000);
    end
    rchk("sw vector reset", dtcnt_pkg::OFF_SW_VECTOR, 16'h0000);
    rchk("unmapped", 8'hF0, 16'h0000);
    chk("response", 16'h0000, {15'h0000, hresp});
    setup(dtcnt_pkg::MODE_NORMAL, 1'b0, 16'h0003, 16'h0000);
    wr(dtcnt_pkg::OFF_IRQ_MASK, 16'h0001);
    set_en(0, 8'h80);
    for (k = 0; k < 3; k++) begin
      act(1'b1, 6'd7);
      chk("units", 16'h0001, 16'(strobes - s0));
      rchk("count a", dtcnt_pkg::OFF_COUNT_A, 16'(2 - k));
      rchk("enable a", eo(0), (k < 2) ? 16'h0080 : 16'h0000);
      chk("irq", {15'h0000, k == 2}, {15'h0000, irq});
    end
    chk("vector address", 16'h0420, last_vec);
    wr(dtcnt_pkg::OFF_IRQ_MASK, 16'h0000);
    rchk("status", dtcnt_pkg::OFF_IRQ_STATUS, 16'h0001);
    chk("masked irq", 16'h0000, {15'h0000, irq});
    wr(dtcnt_pkg::OFF_IRQ_MASK, 16'h0001);
    wr(dtcnt_pkg::OFF_IRQ_STATUS, 16'h0001);
    rchk("status cleared", dtcnt_pkg::OFF_IRQ_STATUS, 16'h0000);
    chk("cleared irq", 16'h0000, {15'h0000, irq});
    for (k = 0; k < 7; k++) begin
      setup(tm[k], 1'b0, ts[k], 16'h0000);
      set_en(0, 8'h80);
      act(1'b1, 6'd7);
      rchk("count encoding", dtcnt_pkg::OFF_COUNT_A, te[k]);
      if (tm[k] == dtcnt_pkg::MODE_NORMAL) begin
        rchk("end clear", eo(0), (te[k] == 16'h0000) ? 16'h0000 : 16'h0080);
      end
    end
    setup(dtcnt_pkg::MODE_BLOCK, 1'b0, 16'h0303, 16'h0002);
    set_en(0, 8'h80);
    act(1'b1, 6'd7);
    chk("block units", 16'h0003, 16'(strobes - s0));
    rchk("block size", dtcnt_pkg::OFF_COUNT_A, 16'h0303);
    rchk("block count", dtcnt_pkg::OFF_COUNT_B, 16'h0001);
    rchk("block enable", eo(0), 16'h0080);
    act(1'b1, 6'd7);
    rchk("block end", dtcnt_pkg::OFF_COUNT_B, 16'h0000);
    rchk("block end enable", eo(0), 16'h0000);
    setup(dtcnt_pkg::MODE_BLOCK, 1'b0, 16'h0000, 16'h0001);
    set_en(0, 8'h80);
    act(1'b1, 6'd7);
    chk("block of zero", 16'h0100, 16'(strobes - s0));
    for (k = 0; k < 3; k++) begin
      setup(dtcnt_pkg::MODE_NORMAL, 1'b1, 16'h0005, 16'h0000);
      set_en(vr[k], vb[k]);
      act(1'b1, vi[k]);
      chk("source vector", dtcnt_pkg::VEC_BASE + 16'(2 * vn[k]), last_vec);
      rchk("select clear", eo(vr[k]), 16'h0000);
      rchk("select count", dtcnt_pkg::OFF_COUNT_A, 16'h0004);
      rchk("select status", dtcnt_pkg::OFF_IRQ_STATUS, 16'h0001);
    end
    setup(dtcnt_pkg::MODE_PROHIB, 1'b0, 16'h0005, 16'h0000);
    set_en(0, 8'h80);
    act(1'b1, 6'd7);
    chk("prohibited units", 16'h0000, 16'(strobes - s0));
    rchk("prohibited status", dtcnt_pkg::OFF_IRQ_STATUS, 16'h0004);
    rchk("prohibited enable", eo(0), 16'h0000);
    setup(dtcnt_pkg::MODE_NORMAL, 1'b0, 16'h0002, 16'h0000);
    wr(dtcnt_pkg::OFF_SW_VECTOR, 16'h0090);
    act(1'b0, 6'd0);
    chk("sw units", 16'h0001, 16'(strobes - s0));
    chk("sw vector address", 16'h0420, last_vec);
    rchk("sw enable cleared", dtcnt_pkg::OFF_SW_VECTOR, 16'h0010);
    setup(dtcnt_pkg::MODE_NORMAL, 1'b0, 16'h0001, 16'h0000);
    wr(dtcnt_pkg::OFF_SW_VECTOR, 16'h0090);
    act(1'b0, 6'd0);
    rchk("sw enable kept", dtcnt_pkg::OFF_SW_VECTOR, 16'h0090);
    rchk("sw end status", dtcnt_pkg::OFF_IRQ_STATUS, 16'h0003);
    wr(dtcnt_pkg::OFF_SW_VECTOR, 16'h0005);
    rchk("sw vector locked", dtcnt_pkg::OFF_SW_VECTOR, 16'h0090);
    wr(dtcnt_pkg::OFF_MODE, 16'h0000);
    rchk("sw enable released", dtcnt_pkg::OFF_SW_VECTOR, 16'h0010);
    // chained: count runs out, yet flag and enable stay, so the source keeps firing
    setup(dtcnt_pkg::MODE_NORMAL, 1'b0, 16'h0001, 16'h0000);
    wr(dtcnt_pkg::OFF_MODE, 16'(1 << dtcnt_pkg::CHAIN_BIT));
    set_en(0, 8'h80);
    act(1'b1, 6'd7);
    chk("chain units", 16'h0001, 16'(strobes - s0));
    rchk("chain enable", eo(0), 16'h0080);
    rchk("chain status", dtcnt_pkg::OFF_IRQ_STATUS, 16'h0000);
    results();
  end
endmodule : transfer_count_and_activation_tb_top
